// >>> hw/tcp_regs.svh
/*
  Constants for the sixteen-bit timer/capture/pulse unit: field codes,
  reset values and timing counts.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// ----------------------------------------
// Operating mode field codes
// ----------------------------------------
`define TCP_MODE_STOP      2'h0
`define TCP_MODE_FREE      2'h1
`define TCP_MODE_EDGE_CLR  2'h2
`define TCP_MODE_MATCH_CLR 2'h3

// ----------------------------------------
// Count clock selector codes
// ----------------------------------------
`define TCP_CLK_DIV1       2'h0
`define TCP_CLK_DIV4       2'h1
`define TCP_CLK_DIV16      2'h2
`define TCP_CLK_EDGE       2'h3

// ----------------------------------------
// Valid edge codes
// ----------------------------------------
`define TCP_EDGE_FALL      2'h0
`define TCP_EDGE_RISE      2'h1
`define TCP_EDGE_NONE      2'h2
`define TCP_EDGE_BOTH      2'h3

// ----------------------------------------
// Reset values and divider counts
// ----------------------------------------
`define TCP_COUNT_RESET    16'h0000
`define TCP_COMPARE_RESET  16'h0000
`define TCP_DIV4_LAST      4'h3
`define TCP_DIV16_LAST     4'hf

`endif

// >>> hw/tcp_pkg.sv
/*
  Types of the sixteen-bit timer/capture/pulse unit.
  Assumes nothing of its surroundings.
*/
package tcp_pkg;

  typedef logic [15:0] tcp_word_t;

endpackage

// >>> hw/tcp_edge_det.sv
/*
  Valid edge detector for one input pin of the timer unit.
  Assumes the pin is synchronous to the clock.
*/
`timescale 1ns/1ps
`include "tcp_regs.svh"

module tcp_edge_det (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [1:0] edge_sel_i,
  input  wire logic       pin_i,
  // Result
  output logic            edge_o
);

  logic prev_r;
  logic ever_run_r;
  logic run_d_r;
  logic first_start;
  logic prev_eff;
  logic rise;
  logic fall;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  // Only the very first enable sees a low history, so a high pin looks like a rise
  assign first_start = run_i & ~run_d_r & ~ever_run_r;
  assign prev_eff    = first_start ? 1'b0 : prev_r;
  assign rise        = pin_i & ~prev_eff;
  assign fall        = ~pin_i & prev_eff;

  // Edge selection, gated by run
  assign edge_o = run_i & (((edge_sel_i == `TCP_EDGE_RISE) & rise) |
                           ((edge_sel_i == `TCP_EDGE_FALL) & fall) |
                           ((edge_sel_i == `TCP_EDGE_BOTH) & (rise | fall)));

  // History keeps tracking the pin while stopped, so re-enabling sees no false edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r     <= 1'b0;
      run_d_r    <= 1'b0;
      ever_run_r <= 1'b0;
    end else begin
      prev_r     <= pin_i;
      run_d_r    <= run_i;
      ever_run_r <= ever_run_r | run_i;
    end
  end

endmodule

// >>> hw/tcp_timer.sv
/*
  Sixteen-bit timer/event counter with two capture/compare registers,
  count clock prescaler, pulse and one-shot output.
  Assumes software-driven control bits as ports; pins synchronous to CLK_I.
*/
`timescale 1ns/1ps
`include "tcp_regs.svh"

module tcp_timer (
  // Clock and reset
  input  wire logic            CLK_I,
  input  wire logic            RST_I,
  // Mode and clock selection
  input  wire logic            OP_MODE_SEL_HI_I,
  input  wire logic            OP_MODE_SEL_LO_I,
  input  wire logic            COUNT_CLOCK_SEL_HI_I,
  input  wire logic            COUNT_CLOCK_SEL_LO_I,
  input  wire logic [1:0]      FIRST_EDGE_SEL_I,
  input  wire logic [1:0]      SECOND_EDGE_SEL_I,
  // Capture/compare configuration
  input  wire logic            PERIOD_CAPTURE_I,
  input  wire logic            DUTY_CAPTURE_I,
  input  wire logic            PERIOD_WR_I,
  input  wire logic            DUTY_WR_I,
  input  wire tcp_pkg::tcp_word_t WR_DATA_I,
  // Output control
  input  wire logic            INVERT_ON_FIRST_MATCH_I,
  input  wire logic            INVERT_ON_SECOND_MATCH_I,
  input  wire logic            TIMER_OUTPUT_ENABLE_I,
  input  wire logic            OUTPUT_LEVEL_SET_I,
  input  wire logic            OUTPUT_LEVEL_RESET_I,
  input  wire logic            PROGRAMMABLE_PULSE_MODE_I,
  input  wire logic            ONE_SHOT_MODE_I,
  input  wire logic            ONE_SHOT_SOFT_TRIGGER_I,
  // Pins
  input  wire logic            FIRST_EDGE_INPUT_I,
  input  wire logic            SECOND_EDGE_INPUT_I,
  output logic                 TIMER_OUTPUT_PIN_O,
  output logic                 SHARED_PORT_PIN_OE_O,
  // Status
  output tcp_pkg::tcp_word_t   COUNT_VALUE_O,
  output tcp_pkg::tcp_word_t   PERIOD_COMPARE_REG_O,
  output tcp_pkg::tcp_word_t   DUTY_COMPARE_REG_O,
  output logic                 FIRST_MATCH_O,
  output logic                 SECOND_MATCH_O
);

  logic [1:0]         mode;
  logic [1:0]         clk_sel;
  logic               run;
  logic [3:0]         div_r;
  logic [3:0]         div_nxt;
  logic               tick;
  tcp_pkg::tcp_word_t count_r;
  tcp_pkg::tcp_word_t count_nxt;
  tcp_pkg::tcp_word_t period_r;
  tcp_pkg::tcp_word_t duty_r;
  logic               edge1;
  logic               edge2;
  logic               match1;
  logic               match2;
  logic               out_r;
  logic               shot_r;
  logic               trig;
  logic               edge_clr;
  logic               cnt_clr;
  logic               pin_func_out;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign mode    = {OP_MODE_SEL_HI_I, OP_MODE_SEL_LO_I};
  assign clk_sel = {COUNT_CLOCK_SEL_HI_I, COUNT_CLOCK_SEL_LO_I};
  assign run     = (mode != `TCP_MODE_STOP);

  // Pin edge detectors
  tcp_edge_det u_edge1 (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .run_i      (run),
    .edge_sel_i (FIRST_EDGE_SEL_I),
    .pin_i      (FIRST_EDGE_INPUT_I),
    .edge_o     (edge1)
  );

  // Second pin edge only when the shared pin is not the timer output
  tcp_edge_det u_edge2 (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .run_i      (run & ~TIMER_OUTPUT_ENABLE_I),
    .edge_sel_i (SECOND_EDGE_SEL_I),
    .pin_i      (SECOND_EDGE_INPUT_I),
    .edge_o     (edge2)
  );

  // ----------------------------------------
  // Prescaler: one-cycle count enable
  // ----------------------------------------
  // The divider free-runs, so the first tick after start lands anywhere in a period
  assign div_nxt = (div_r == `TCP_DIV16_LAST) ? 4'h0 : div_r + 4'h1;
  assign tick = (clk_sel == `TCP_CLK_DIV1) ? 1'b1 :
                (clk_sel == `TCP_CLK_DIV4) ? (div_r[1:0] == 2'(`TCP_DIV4_LAST)) :
                (clk_sel == `TCP_CLK_DIV16) ? (div_r == `TCP_DIV16_LAST) :
                edge1;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  assign match1   = run & (count_r == period_r);
  assign match2   = run & (count_r == duty_r);
  // Edge clear mode with edge count clock: counter pinned at zero
  assign edge_clr = (mode == `TCP_MODE_EDGE_CLR) &
                    ((clk_sel == `TCP_CLK_EDGE) | edge1);
  assign cnt_clr  = edge_clr |
                    ((mode == `TCP_MODE_MATCH_CLR | PROGRAMMABLE_PULSE_MODE_I) &
                     match1 & tick);
  assign count_nxt = !run ? `TCP_COUNT_RESET :
                     cnt_clr ? `TCP_COUNT_RESET :
                     tick ? count_r + 16'h0001 : count_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      count_r <= `TCP_COUNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------
  // Capture/compare registers
  // ----------------------------------------
  // Capture only in capture setting; edge count clock excludes first pin capture
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      period_r <= `TCP_COMPARE_RESET;
      duty_r   <= `TCP_COMPARE_RESET;
    end else begin
      if (PERIOD_WR_I & ~PERIOD_CAPTURE_I) begin
        period_r <= WR_DATA_I;
      end else if (PERIOD_CAPTURE_I & run & edge2) begin
        period_r <= count_r;
      end
      if (DUTY_WR_I & ~DUTY_CAPTURE_I) begin
        duty_r <= WR_DATA_I;
      end else if (DUTY_CAPTURE_I & run & edge1 & (clk_sel != `TCP_CLK_EDGE)) begin
        duty_r <= count_r;
      end
    end
  end

  // ----------------------------------------
  // Timer output and one-shot
  // ----------------------------------------
  // Pin edge also triggers one-shot, hence the pin must stay steady for soft use
  assign trig = ONE_SHOT_MODE_I & run & ~shot_r &
                (ONE_SHOT_SOFT_TRIGGER_I | edge1);
  assign pin_func_out = TIMER_OUTPUT_ENABLE_I;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      out_r  <= 1'b0;
      shot_r <= 1'b0;
    end else begin
      if (OUTPUT_LEVEL_SET_I) begin
        out_r <= 1'b1;
      end else if (OUTPUT_LEVEL_RESET_I) begin
        out_r <= 1'b0;
      end else if (ONE_SHOT_MODE_I) begin
        if (trig) begin
          shot_r <= 1'b1;
        end else if (shot_r & match2 & tick & INVERT_ON_SECOND_MATCH_I) begin
          out_r <= ~out_r;
        end else if (shot_r & match1 & tick & INVERT_ON_FIRST_MATCH_I) begin
          out_r  <= ~out_r;
          shot_r <= 1'b0;
        end
      end else if (TIMER_OUTPUT_ENABLE_I & tick) begin
        if ((match1 & INVERT_ON_FIRST_MATCH_I) ^ (match2 & INVERT_ON_SECOND_MATCH_I)) begin
          out_r <= ~out_r;
        end
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TIMER_OUTPUT_PIN_O   <= 1'b0;
      SHARED_PORT_PIN_OE_O <= 1'b0;
      COUNT_VALUE_O        <= `TCP_COUNT_RESET;
      PERIOD_COMPARE_REG_O <= `TCP_COMPARE_RESET;
      DUTY_COMPARE_REG_O   <= `TCP_COMPARE_RESET;
      FIRST_MATCH_O        <= 1'b0;
      SECOND_MATCH_O       <= 1'b0;
    end else begin
      TIMER_OUTPUT_PIN_O   <= out_r & pin_func_out;
      SHARED_PORT_PIN_OE_O <= pin_func_out;
      COUNT_VALUE_O        <= count_r;
      PERIOD_COMPARE_REG_O <= period_r;
      DUTY_COMPARE_REG_O   <= duty_r;
      FIRST_MATCH_O        <= match1 & tick;
      SECOND_MATCH_O       <= match2 & tick;
    end
  end

endmodule

// >>> test/tcp_timer_properties.sv
/* Port checker for tcp_timer, bound at the foot of this file.
   Assumes one clock and a two-edge input-to-output latency. */
`timescale 1ns/1ps
module tcp_timer_properties (
  input wire logic               CLK_I,
  input wire logic               RST_I,
  input wire logic               OP_MODE_SEL_HI_I,
  input wire logic               OP_MODE_SEL_LO_I,
  input wire logic               COUNT_CLOCK_SEL_HI_I,
  input wire logic               COUNT_CLOCK_SEL_LO_I,
  input wire logic               TIMER_OUTPUT_ENABLE_I,
  input wire logic               OUTPUT_LEVEL_SET_I,
  input wire logic               OUTPUT_LEVEL_RESET_I,
  input wire logic               TIMER_OUTPUT_PIN_O,
  input wire tcp_pkg::tcp_word_t COUNT_VALUE_O
);
  // Fields decoded; waits of three or four cycles cover the input-to-output latency
  wire logic [1:0] mode_w = {OP_MODE_SEL_HI_I, OP_MODE_SEL_LO_I};
  wire logic [1:0] csel_w = {COUNT_CLOCK_SEL_HI_I, COUNT_CLOCK_SEL_LO_I};
  wire logic       en_w   = (mode_w == 2'h0) && TIMER_OUTPUT_ENABLE_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  count_holds_a: assert property ((mode_w == 2'h0) [*4] |-> $stable(COUNT_VALUE_O))
    else $error("count moved while stopped");
  count_runs_a: assert property (
    (mode_w == 2'h1 && csel_w == 2'h0) [*4] |-> COUNT_VALUE_O != $past(COUNT_VALUE_O))
    else $error("count idle while running");
  edge_clear_a: assert property (
    (mode_w == 2'h2 && csel_w == 2'h3) [*4] |-> COUNT_VALUE_O == 16'h0000)
    else $error("count not held cleared");
  output_off_a: assert property (!TIMER_OUTPUT_ENABLE_I [*3] |-> !TIMER_OUTPUT_PIN_O)
    else $error("output driven while disabled");
  level_high_a: assert property (
    en_w [*3] ##0 OUTPUT_LEVEL_SET_I ##1 (en_w && !OUTPUT_LEVEL_RESET_I) |=> TIMER_OUTPUT_PIN_O)
    else $error("output not forced high");
  level_low_a: assert property (
    en_w [*3] ##0 (OUTPUT_LEVEL_RESET_I && !OUTPUT_LEVEL_SET_I) ##1 (en_w && !OUTPUT_LEVEL_SET_I)
    |=> !TIMER_OUTPUT_PIN_O) else $error("output not forced low");
  cover property (en_w [*3] ##0 OUTPUT_LEVEL_SET_I);
  cover property ((mode_w == 2'h3) [*8]);
  cover property ((mode_w == 2'h2 && csel_w == 2'h3) [*4]);
endmodule
bind tcp_timer tcp_timer_properties chk_u (.CLK_I(CLK_I), .RST_I(RST_I),
  .OP_MODE_SEL_HI_I(OP_MODE_SEL_HI_I), .OP_MODE_SEL_LO_I(OP_MODE_SEL_LO_I),
  .COUNT_CLOCK_SEL_HI_I(COUNT_CLOCK_SEL_HI_I), .COUNT_CLOCK_SEL_LO_I(COUNT_CLOCK_SEL_LO_I),
  .TIMER_OUTPUT_ENABLE_I(TIMER_OUTPUT_ENABLE_I), .OUTPUT_LEVEL_SET_I(OUTPUT_LEVEL_SET_I),
  .OUTPUT_LEVEL_RESET_I(OUTPUT_LEVEL_RESET_I), .TIMER_OUTPUT_PIN_O(TIMER_OUTPUT_PIN_O),
  .COUNT_VALUE_O(COUNT_VALUE_O));

// >>> test/tcp_pin_model.sv
/* Far side of tcp_timer: drives both edge input pins.
   Assumes requests arrive one cycle wide at the falling edge. */
`timescale 1ns/1ps
module tcp_pin_model #(
  parameter int HOLD = 4
) (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic idle_i,
  output logic      first_pin_o,
  output logic      second_pin_o
);
  int left = 0;
  // Pulse holds the pin for four clock cycles so it is never missed
  always @(negedge clk_i) begin
    if (go_i) left <= HOLD;
    else if (left != 0) left <= left - 1;
  end
  // First pin moves only on request; second stays quiet, pin serves output
  assign first_pin_o  = idle_i ^ (left != 0);
  assign second_pin_o = 1'b0;
endmodule

// >>> test/tcp_timer_tb_top.sv
/* Self-checking bench for tcp_timer, stimulus at the falling edge.
   Assumes the pin model and the bound checker. */
`timescale 1ns/1ps
module tcp_timer_tb_top;
  logic               clk, rst, inv1, inv2, oe, lset, lres, ppm, osm, ost, pwr, dwr, fgo, fid;
  logic [1:0]         mode, csel, fsel;
  tcp_pkg::tcp_word_t wdat, cnt, preg, dreg, held;
  logic               pin1, pin2, tout, toe, m1, m2, dcap;
  int                 fail_count, samples_checked, n1, n2, nhi;
  tcp_pin_model #(.HOLD(4)) pins_u (.clk_i(clk), .go_i(fgo), .idle_i(fid),
    .first_pin_o(pin1), .second_pin_o(pin2));
  tcp_timer dut_u (.CLK_I(clk), .RST_I(rst), .OP_MODE_SEL_HI_I(mode[1]),
    .OP_MODE_SEL_LO_I(mode[0]), .COUNT_CLOCK_SEL_HI_I(csel[1]), .COUNT_CLOCK_SEL_LO_I(csel[0]),
    .FIRST_EDGE_SEL_I(fsel), .SECOND_EDGE_SEL_I(2'h2), .PERIOD_CAPTURE_I(1'b0),
    .DUTY_CAPTURE_I(dcap), .PERIOD_WR_I(pwr), .DUTY_WR_I(dwr), .WR_DATA_I(wdat),
    .INVERT_ON_FIRST_MATCH_I(inv1), .INVERT_ON_SECOND_MATCH_I(inv2),
    .TIMER_OUTPUT_ENABLE_I(oe), .OUTPUT_LEVEL_SET_I(lset), .OUTPUT_LEVEL_RESET_I(lres),
    .PROGRAMMABLE_PULSE_MODE_I(ppm), .ONE_SHOT_MODE_I(osm), .ONE_SHOT_SOFT_TRIGGER_I(ost),
    .FIRST_EDGE_INPUT_I(pin1), .SECOND_EDGE_INPUT_I(pin2), .TIMER_OUTPUT_PIN_O(tout),
    .SHARED_PORT_PIN_OE_O(toe), .COUNT_VALUE_O(cnt), .PERIOD_COMPARE_REG_O(preg),
    .DUTY_COMPARE_REG_O(dreg), .FIRST_MATCH_O(m1), .SECOND_MATCH_O(m2));
  // ----
  // Access tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Reset also clears every timer control bit so each scenario starts clean; fid keeps its level
  task automatic restart(input int n);
    {mode, csel, fsel, inv1, inv2, oe, lset, lres, ppm, osm, ost, pwr, dwr, dcap} = '0;
    rst = 1'b1;
    tick(n);
    rst = 1'b0;
    tick(1);
  endtask
  task automatic load(input logic [15:0] per, input logic [15:0] duty);
    wdat = per;
    {pwr, dwr} = 2'h2;
    tick(1);
    wdat = duty;
    {pwr, dwr} = 2'h1;
    tick(1);
    dwr = 1'b0;
  endtask
  // Inversion first, enable alone, then exactly one level bit
  task automatic out_on(input logic hi);
    {inv1, inv2} = 2'h3;
    tick(1);
    oe = 1'b1;
    tick(3);
    {lset, lres} = {hi, !hi};
    tick(1);
    {lset, lres} = 2'h0;
  endtask
  task automatic pulse;
    fgo <= 1'b1;
    tick(1);
    fgo <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // 10 MHz clock; the watchdog allows about fourteen times the expected run
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 4000);
    fail_count++;
    tally_and_finish();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    fgo = 1'b0;
    fid = 1'b0;
    wdat = '0;
    restart(12);
    check("count at reset", cnt, 16'h0000);
    mode = 2'h1;
    tick(10);
    check("count window", cnt >= 16'h0007 && cnt <= 16'h000a, 1'b1);
    mode = 2'h0;
    tick(3);
    held = cnt;
    tick(5);
    check("stopped count", cnt, held);
    mode = 2'h1;
    tick(4);
    check("resumed count", cnt > held, 1'b1);
    mode = 2'h0;
    out_on(1'b1);
    tick(3);
    check("level set", tout, 1'b1);
    check("pin enable", toe, 1'b1);
    out_on(1'b0);
    tick(3);
    check("level reset", tout, 1'b0);
    // Pulse mode, frame of ten counts: one match of each kind per frame
    restart(2);
    load(16'h0009, 16'h0004);
    out_on(1'b0);
    {ppm, mode} = {1'b1, 2'h3};
    tick(20);
    check("period reg", preg, 16'h0009);
    check("duty reg", dreg, 16'h0004);
    {n1, n2, nhi} = '0;
    repeat (100) begin
      n1 += m1;
      n2 += m2;
      nhi += tout;
      tick(1);
    end
    check("period matches", n1[15:0], 16'h000a);
    check("duty matches", n2[15:0], 16'h000a);
    check("pulse high time", nhi[15:0], 16'h0032);
    // Edge count clock in edge clear mode holds the count at zero
    restart(2);
    {csel, mode} = 4'he;
    pulse();
    tick(8);
    pulse();
    tick(8);
    check("edge clear hold", cnt, 16'h0000);
    // Pin already high at first enable counts as one rise, not on re-enable
    fid = 1'b1;
    restart(2);
    {fsel, csel} = 4'h7;
    tick(1);
    mode = 2'h1;
    tick(6);
    check("first enable rise", cnt, 16'h0001);
    mode = 2'h0;
    tick(3);
    held = cnt;
    mode = 2'h1;
    tick(6);
    check("re-enable no rise", cnt, held);
    pulse();
    tick(8);
    check("pin rise counted", cnt, held + 16'h0001);
    // Soft-triggered one-shot: high from duty match to period match
    fid = 1'b0;
    restart(2);
    load(16'h0008, 16'h0003);
    out_on(1'b0);
    {osm, mode, ost} = 4'hb;
    tick(1);
    ost = 1'b0;
    nhi = 0;
    repeat (30) begin
      nhi += tout;
      tick(1);
    end
    check("one-shot width", nhi[15:0], 16'h0005);
    // Rising first pin captures the running count into the duty register
    restart(2);
    {fsel, dcap} = 3'h3;
    tick(1);
    mode = 2'h1;
    pulse();
    tick(4);
    check("captured count", dreg, 16'h0001);
    tally_and_finish();
  end
endmodule
